// ---- rtl/bsl_pkg.sv ----
// package for the burner sequence and lockout supervisor
// assumes a 200 MHz timebase clock and a one-second tick derived inside
package bsl_pkg;

  // clock rate and second tick
  localparam int unsigned CLK_HZ           = 200_000_000;
  localparam int unsigned TICK_CYCLES      = CLK_HZ;

  // period lengths in seconds, except LOCK_HOURS in hours
  localparam int unsigned VALID_S          = 2;
  localparam int unsigned HOLD_SHOW_S      = 5;
  localparam int unsigned HOLD_MAX_S       = 240;
  localparam int unsigned STBY_FLAME_S     = 40;
  localparam int unsigned STBY_PII_S       = 30;
  localparam int unsigned STBY_AIR_S       = 120;
  localparam int unsigned PURGE_MIN_S      = 2;
  localparam int unsigned PURGE_MAX_S      = 1800;
  localparam int unsigned FIRE_SW_MAX_S    = 300;
  localparam int unsigned AIR_CLOSE_S      = 10;
  localparam int unsigned PREIGN_S         = 3;
  localparam int unsigned PILOT_SETTLE_S   = 5;
  localparam int unsigned MAIN_STAB_S      = 5;
  localparam int unsigned LONG_SAFETY_S    = 5;
  localparam int unsigned SHORT_SAFETY_S   = 3;
  localparam int unsigned POSTPURGE_S      = 15;
  localparam int unsigned LOCK_HOURS       = 200;
  localparam int unsigned LOCK_HOURS_S     = LOCK_HOURS * 3600;

  // second counter width
  localparam int unsigned SEC_W            = 11;
  localparam int unsigned HOUR_W           = 20;

  // sequence states, gray along the normal path from validate through post-purge
  typedef enum logic [3:0] {
    BSL_ST_VALIDATE = 4'h0,
    BSL_ST_STANDBY  = 4'h1,
    BSL_ST_PURGE_HI = 4'h3,
    BSL_ST_PURGE    = 4'h2,
    BSL_ST_PURGE_LO = 4'h6,
    BSL_ST_PREIGN   = 4'h7,
    BSL_ST_SAFETY1  = 4'h5,
    BSL_ST_PILOT    = 4'h4,
    BSL_ST_MAIN     = 4'hc,
    BSL_ST_MAINSTAB = 4'hd,
    BSL_ST_RUN      = 4'hf,
    BSL_ST_POST     = 4'he,
    BSL_ST_HOLD     = 4'ha,
    BSL_ST_LOCKOUT  = 4'h8
  } bsl_state_t;

  // field inputs, all closed or present when high
  typedef struct packed {
    logic call_heat;
    logic burner_sw;
    logic limits;
    logic lockout_in;
    logic preign_ilk;
    logic airflow;
    logic hi_fire_sw;
    logic lo_fire_sw;
    logic flame;
    logic air_jumper;
  } bsl_field_t;

  // sensed output terminals, energized when high
  typedef struct packed {
    logic ign;
    logic pilot;
    logic ipilot;
    logic main;
  } bsl_sense_t;

  // driven outputs
  typedef struct packed {
    logic blower;
    logic ign;
    logic pilot;
    logic ipilot;
    logic main;
    logic drive_hi;
    logic drive_lo;
    logic alarm;
    logic hold;
  } bsl_drive_t;

endpackage

// ---- rtl/bsl_sync.sv ----
// two flip-flop synchroniser for a bus of field levels
// assumes inputs are asynchronous to ref_clk_in
`timescale 1ns/1ps
`default_nettype none
module bsl_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         ref_clk_in,
  input  wire logic         arst_n_in,
  // levels
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  // first stage feeds only the second
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule
`default_nettype wire

// ---- rtl/bsl_core.sv ----
// burner sequence and safety lockout supervisor
// assumes field pins are asynchronous and arrive as closed/present high
`timescale 1ns/1ps
`default_nettype none
module bsl_core #(
  parameter int unsigned TICK_CYCLES = bsl_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic              ref_clk_in,
  input  wire logic              arst_n_in,
  // field pins and terminal sensing
  input  wire bsl_pkg::bsl_field_t field_in,
  input  wire bsl_pkg::bsl_sense_t sense_in,
  // supply monitor and card
  input  wire logic              supply_ok_in,
  input  wire logic              card_ok_in,
  input  wire logic [10:0]       card_purge_s_in,
  input  wire logic              int_fault_in,
  // jumpers and reset request
  input  wire logic [2:0]        jumpers_in,
  input  wire logic              lockout_reset_in,
  // outputs
  output bsl_pkg::bsl_drive_t    drive_out,
  output bsl_pkg::bsl_state_t    state_out
);

  localparam int unsigned FW = $bits(bsl_pkg::bsl_field_t);
  localparam int unsigned SW = $bits(bsl_pkg::bsl_sense_t);
  localparam int unsigned AW = FW + SW + 8;

  bsl_pkg::bsl_field_t fld;
  bsl_pkg::bsl_sense_t sns;
  logic                sup_ok;
  logic                card_ok;
  logic                ifault;
  logic [2:0]          jmp;
  logic                rst_req;
  logic [AW-1:0]       sync_o;

  // all pins except card_purge_s_in pass two flip-flops
  bsl_sync #(.W(AW)) u_sync (
    .ref_clk_in (ref_clk_in),
    .arst_n_in  (arst_n_in),
    .async_in   ({field_in, sense_in, supply_ok_in, card_ok_in, int_fault_in,
                  jumpers_in, lockout_reset_in, 1'b0}),
    .sync_out   (sync_o)
  );
  assign {fld, sns, sup_ok, card_ok, ifault, jmp, rst_req} = sync_o[AW-1:1];

  // one-second tick
  logic [31:0] div_q;
  logic        tick;
  assign tick = (div_q == TICK_CYCLES - 1);
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) div_q <= '0;
    else            div_q <= tick ? '0 : div_q + 32'h1;
  end

  bsl_pkg::bsl_state_t st_q, st_d;
  logic [10:0] sec_q;       // seconds in current state or phase
  logic [10:0] aux_q;       // secondary timer (fire switch, hold)
  logic [5:0]  pii_q;       // accumulated interlock open time
  logic [19:0] main_s_q;    // main valve operating seconds
  logic [2:0]  jmp_ref_q;
  logic        jmp_lock_q;
  logic        jmp_cap_q;
  logic        purge_cnt_q; // purge timing running
  logic [1:0]  settle_q;    // cycles since the last state change, saturating
  logic [1:0]  live_q;      // synchroniser filled after reset

  // the synchroniser comes out of reset at all zeros, which reads as a pulled
  // card, a bad supply and an open lockout input; the sequencer waits until
  // the first real pin levels have passed both flops, or every reset, mid-run
  // ones included, would end in an immediate lockout

  // timing jumpers
  wire [10:0] safety1_s = jmp_ref_q[0] ? 11'(bsl_pkg::LONG_SAFETY_S)
                                       : 11'(bsl_pkg::SHORT_SAFETY_S);
  wire [10:0] trial_s   = jmp_ref_q[1] ? 11'(bsl_pkg::LONG_SAFETY_S)
                                       : 11'(bsl_pkg::SHORT_SAFETY_S);
  wire        air_en    = ~jmp_ref_q[2];
  // purge card value clamped into its range
  wire [10:0] purge_s   = (card_purge_s_in < 11'(bsl_pkg::PURGE_MIN_S))
                          ? 11'(bsl_pkg::PURGE_MIN_S)
                          : (card_purge_s_in > 11'(bsl_pkg::PURGE_MAX_S))
                          ? 11'(bsl_pkg::PURGE_MAX_S) : card_purge_s_in;

  function automatic logic secs(input logic [10:0] n, input logic [10:0] lim);
    secs = (n >= lim);
  endfunction

  // terminal sensing trails each relay change by the output flop and the two
  // sync flops, so terminal checks wait three cycles after every state change;
  // without this every step that switches a relay would trip its own check
  wire                 sns_live = (settle_q == 2'h3);
  bsl_pkg::bsl_sense_t son;     // sensed energized, once settled
  bsl_pkg::bsl_sense_t soff;    // sensed de-energized, once settled
  assign son  = sns_live ? sns : '0;
  assign soff = sns_live ? bsl_pkg::bsl_sense_t'(~sns) : '0;

  // common checks
  wire any_out   = son.ign | son.pilot | son.ipilot | son.main;
  wire card_bad  = ~card_ok | ifault;
  wire jmp_bad   = jmp_lock_q & (jmp != jmp_ref_q);
  wire fire_path = fld.burner_sw & fld.limits;
  wire all_ok    = fld.call_heat & fire_path & fld.lockout_in & fld.preign_ilk
                   & sns_live & ~any_out & ~fld.flame
                   & (air_en ? ~fld.airflow : fld.air_jumper);

  // fault decode per state
  logic fault;
  always_comb begin
    fault = card_bad;
    unique case (st_q)
      bsl_pkg::BSL_ST_VALIDATE: fault = card_bad | jmp_bad;
      bsl_pkg::BSL_ST_HOLD:
        fault = card_bad | secs(aux_q, 11'(bsl_pkg::HOLD_MAX_S));
      bsl_pkg::BSL_ST_STANDBY:
        fault = card_bad | ~fld.lockout_in | any_out
              | (fld.flame & secs(sec_q, 11'(bsl_pkg::STBY_FLAME_S)))
              | (pii_q >= 6'(bsl_pkg::STBY_PII_S))
              | (air_en & secs(aux_q, 11'(bsl_pkg::STBY_AIR_S)));
      bsl_pkg::BSL_ST_PURGE_HI, bsl_pkg::BSL_ST_PURGE, bsl_pkg::BSL_ST_PURGE_LO:
        fault = card_bad | ~fld.preign_ilk | fld.flame | ~fld.lockout_in
              | any_out
              | (~fld.airflow & (purge_cnt_q | secs(sec_q, 11'(bsl_pkg::AIR_CLOSE_S))))
              | (~air_en & ~fld.air_jumper)
              | (st_q != bsl_pkg::BSL_ST_PURGE
                 & secs(aux_q, 11'(bsl_pkg::FIRE_SW_MAX_S)));
      bsl_pkg::BSL_ST_PREIGN:
        fault = card_bad | soff.ign | son.pilot | son.ipilot | son.main
              | ~fld.lockout_in | ~fld.airflow | ~fld.preign_ilk | fld.flame;
      bsl_pkg::BSL_ST_SAFETY1:
        fault = card_bad | soff.ign | soff.pilot | soff.ipilot | son.main
              | ~fld.lockout_in | ~fld.airflow | ~fld.lo_fire_sw
              | (~fld.flame & secs(sec_q, safety1_s));
      bsl_pkg::BSL_ST_PILOT:
        fault = card_bad | son.ign | soff.pilot | soff.ipilot | son.main
              | ~fld.lockout_in | ~fld.airflow | ~fld.lo_fire_sw | ~fld.flame;
      bsl_pkg::BSL_ST_MAIN, bsl_pkg::BSL_ST_MAINSTAB:
        fault = card_bad | son.ign | soff.ipilot | soff.main
              | (st_q == bsl_pkg::BSL_ST_MAIN ? soff.pilot : son.pilot)
              | ~fld.lockout_in | ~fld.airflow | ~fld.lo_fire_sw | ~fld.flame;
      bsl_pkg::BSL_ST_RUN:
        fault = card_bad | ~fld.flame | ~fld.lockout_in | ~fld.airflow
              | son.ign | son.pilot | soff.main;
      bsl_pkg::BSL_ST_POST: fault = card_bad | any_out;
      bsl_pkg::BSL_ST_LOCKOUT: fault = 1'b0;
      default: fault = 1'b1;
    endcase
  end

  // next state
  always_comb begin
    st_d = st_q;
    if (~live_q[1]) begin
      st_d = st_q;                                                      // pins not through yet
    end else if (st_q == bsl_pkg::BSL_ST_LOCKOUT) begin
      if (rst_req & ~jmp_bad) st_d = bsl_pkg::BSL_ST_VALIDATE;
    end else if (fault) begin
      st_d = bsl_pkg::BSL_ST_LOCKOUT;
    end else if (~sup_ok & st_q != bsl_pkg::BSL_ST_HOLD) begin
      st_d = bsl_pkg::BSL_ST_HOLD;
    end else begin
      unique case (st_q)
        bsl_pkg::BSL_ST_VALIDATE:
          if (secs(sec_q, 11'(bsl_pkg::VALID_S))) st_d = bsl_pkg::BSL_ST_STANDBY;
        bsl_pkg::BSL_ST_HOLD:
          if (sup_ok & secs(sec_q, 11'(bsl_pkg::HOLD_SHOW_S)))
            st_d = bsl_pkg::BSL_ST_VALIDATE;
        bsl_pkg::BSL_ST_STANDBY:
          if (all_ok) st_d = bsl_pkg::BSL_ST_PURGE_HI;
        bsl_pkg::BSL_ST_PURGE_HI:
          if (fld.airflow & fld.hi_fire_sw) st_d = bsl_pkg::BSL_ST_PURGE;
        bsl_pkg::BSL_ST_PURGE:
          if (secs(sec_q, purge_s)) st_d = bsl_pkg::BSL_ST_PURGE_LO;
        bsl_pkg::BSL_ST_PURGE_LO:
          if (fld.lo_fire_sw) st_d = bsl_pkg::BSL_ST_PREIGN;
        bsl_pkg::BSL_ST_PREIGN:
          if (secs(sec_q, 11'(bsl_pkg::PREIGN_S))) st_d = bsl_pkg::BSL_ST_SAFETY1;
        bsl_pkg::BSL_ST_SAFETY1:
          if (fld.flame & secs(sec_q, safety1_s)) st_d = bsl_pkg::BSL_ST_PILOT;
        bsl_pkg::BSL_ST_PILOT:
          if (secs(sec_q, 11'(bsl_pkg::PILOT_SETTLE_S))) st_d = bsl_pkg::BSL_ST_MAIN;
        bsl_pkg::BSL_ST_MAIN:
          if (secs(sec_q, trial_s)) st_d = bsl_pkg::BSL_ST_MAINSTAB;
        bsl_pkg::BSL_ST_MAINSTAB:
          if (secs(sec_q, 11'(bsl_pkg::MAIN_STAB_S))) st_d = bsl_pkg::BSL_ST_RUN;
        bsl_pkg::BSL_ST_RUN:
          if (~(fld.call_heat & fire_path)) st_d = bsl_pkg::BSL_ST_POST;
        bsl_pkg::BSL_ST_POST:
          if (secs(sec_q, 11'(bsl_pkg::POSTPURGE_S))) st_d = bsl_pkg::BSL_ST_STANDBY;
        default: st_d = st_q;
      endcase
    end
  end

  wire changed = (st_d != st_q);
  wire sat_sec = &sec_q;

  // settle counter for terminal checks and start-up fill of the synchroniser
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      settle_q <= '0;
      live_q   <= '0;
    end else begin
      settle_q <= changed ? 2'h0 : settle_q + 2'((settle_q != 2'h3) ? 1 : 0);
      live_q   <= {live_q[0], 1'b1};
    end
  end

  // state and phase timers
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_q        <= bsl_pkg::BSL_ST_VALIDATE;
      sec_q       <= '0;
      purge_cnt_q <= 1'b0;
    end else begin
      st_q        <= st_d;
      sec_q       <= changed ? '0 : sec_q + 11'((tick & ~sat_sec) ? 1 : 0);
      purge_cnt_q <= (st_d == bsl_pkg::BSL_ST_PURGE) | (st_d == bsl_pkg::BSL_ST_PURGE_LO);
    end
  end

  // aux timer: hold time, fire switch wait, standby airflow closed time
  logic aux_run;
  assign aux_run = (st_q == bsl_pkg::BSL_ST_HOLD)
                 | (st_q == bsl_pkg::BSL_ST_PURGE_HI & ~fld.hi_fire_sw)
                 | (st_q == bsl_pkg::BSL_ST_PURGE_LO & ~fld.lo_fire_sw)
                 | (st_q == bsl_pkg::BSL_ST_STANDBY & fld.airflow & fire_path);
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) aux_q <= '0;
    else if (changed) aux_q <= '0;                                     // fresh count per state
    else if (~aux_run & st_q == bsl_pkg::BSL_ST_STANDBY) aux_q <= '0;
    else if (aux_run & tick & ~&aux_q) aux_q <= aux_q + 11'h1;
  end

  // accumulated interlock open time in standby
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) pii_q <= '0;
    else if (st_q != bsl_pkg::BSL_ST_STANDBY) pii_q <= '0;
    else if (~fld.preign_ilk & tick & ~&pii_q) pii_q <= pii_q + 6'h1;
  end

  // jumper capture at startup, locked after main valve hours
  wire main_on = (st_q == bsl_pkg::BSL_ST_MAIN) | (st_q == bsl_pkg::BSL_ST_MAINSTAB)
               | (st_q == bsl_pkg::BSL_ST_RUN);
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      jmp_ref_q  <= '0;
      jmp_cap_q  <= 1'b0;
      jmp_lock_q <= 1'b0;
      main_s_q   <= '0;
    end else begin
      jmp_cap_q <= 1'b1;
      if (~jmp_lock_q & (~jmp_cap_q | st_q == bsl_pkg::BSL_ST_VALIDATE)) jmp_ref_q <= jmp;
      if (main_on & tick & ~jmp_lock_q) main_s_q <= main_s_q + 20'h1;
      if (main_s_q >= 20'(bsl_pkg::LOCK_HOURS_S)) jmp_lock_q <= 1'b1;
    end
  end

  // registered outputs
  bsl_pkg::bsl_drive_t drv_d;
  always_comb begin
    drv_d          = '0;
    drv_d.blower   = (st_d != bsl_pkg::BSL_ST_VALIDATE) & (st_d != bsl_pkg::BSL_ST_HOLD)
                   & (st_d != bsl_pkg::BSL_ST_STANDBY) & (st_d != bsl_pkg::BSL_ST_LOCKOUT);
    drv_d.drive_hi = (st_d == bsl_pkg::BSL_ST_PURGE_HI) | (st_d == bsl_pkg::BSL_ST_PURGE);
    drv_d.drive_lo = (st_d == bsl_pkg::BSL_ST_PURGE_LO) | (st_d == bsl_pkg::BSL_ST_PREIGN)
                   | (st_d == bsl_pkg::BSL_ST_SAFETY1) | (st_d == bsl_pkg::BSL_ST_PILOT)
                   | (st_d == bsl_pkg::BSL_ST_MAIN) | (st_d == bsl_pkg::BSL_ST_MAINSTAB)
                   | (st_d == bsl_pkg::BSL_ST_POST);
    drv_d.ign      = (st_d == bsl_pkg::BSL_ST_PREIGN) | (st_d == bsl_pkg::BSL_ST_SAFETY1);
    drv_d.pilot    = (st_d == bsl_pkg::BSL_ST_SAFETY1) | (st_d == bsl_pkg::BSL_ST_PILOT)
                   | (st_d == bsl_pkg::BSL_ST_MAIN);
    drv_d.ipilot   = drv_d.pilot | (st_d == bsl_pkg::BSL_ST_MAINSTAB);
    drv_d.main     = (st_d == bsl_pkg::BSL_ST_MAIN) | (st_d == bsl_pkg::BSL_ST_MAINSTAB)
                   | (st_d == bsl_pkg::BSL_ST_RUN);
    drv_d.alarm    = (st_d == bsl_pkg::BSL_ST_LOCKOUT);
    drv_d.hold     = (st_d == bsl_pkg::BSL_ST_HOLD);
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      drive_out <= '0;
      state_out <= bsl_pkg::BSL_ST_VALIDATE;
    end else begin
      drive_out <= drv_d;
      state_out <= st_d;
    end
  end

endmodule
`default_nettype wire

// ---- test/bsl_core_asserts.sv ----
// port checker for the burner sequence and lockout supervisor
// assumes it is bound to bsl_core and is handed the same tick length
`timescale 1ns/1ps
`default_nettype none
module bsl_core_chk #(
  parameter int unsigned TICK_CYCLES = 10
) (
  // clock and reset
  input wire logic                ref_clk_in,
  input wire logic                arst_n_in,
  // watched inputs
  input wire bsl_pkg::bsl_field_t field_in,
  input wire bsl_pkg::bsl_sense_t sense_in,
  input wire logic                supply_ok_in,
  input wire logic                card_ok_in,
  input wire logic                int_fault_in,
  input wire logic                lockout_reset_in,
  // watched outputs
  input wire bsl_pkg::bsl_drive_t drive_out,
  input wire bsl_pkg::bsl_state_t state_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);
  // last state and how many cycles it was held
  bsl_pkg::bsl_state_t prev_q;
  logic [31:0]         held_q;
  wire logic           lock_w  = state_out == bsl_pkg::BSL_ST_LOCKOUT;
  wire logic           moved_w = state_out != prev_q;
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      prev_q <= bsl_pkg::BSL_ST_VALIDATE;
      held_q <= '0;
    end else begin
      prev_q <= state_out;
      held_q <= moved_w ? 32'h1 : held_q + 32'h1;
    end
  end
  AST_CARD_LOCK: assert property (!card_ok_in [*5] |-> lock_w)
    else $error("card fault without lockout");
  AST_FAULT_LOCK: assert property (int_fault_in [*5] |-> lock_w)
    else $error("internal fault without lockout");
  AST_LOCK_SAFE: assert property (lock_w && $past(lock_w) |-> drive_out.alarm
    && !(drive_out.ign || drive_out.pilot || drive_out.ipilot || drive_out.main))
    else $error("lockout left an output on");
  AST_LOCK_LATCH: assert property (!lockout_reset_in [*4] ##0 lock_w |=> lock_w)
    else $error("lockout left without reset");
  AST_HOLD_ENTER: assert property (!supply_ok_in [*5] ##0 !lock_w |->
    state_out == bsl_pkg::BSL_ST_HOLD) else $error("bad supply without hold");
  AST_HOLD_SHOW: assert property (moved_w && prev_q == bsl_pkg::BSL_ST_HOLD &&
    state_out == bsl_pkg::BSL_ST_VALIDATE |-> held_q >= (bsl_pkg::HOLD_SHOW_S - 1) * TICK_CYCLES)
    else $error("hold shown too briefly");
  AST_HOLD_MAX: assert property (prev_q == bsl_pkg::BSL_ST_HOLD && !moved_w |->
    held_q <= (bsl_pkg::HOLD_MAX_S + 1) * TICK_CYCLES) else $error("hold outlasted limit");
  AST_VALID_TIME: assert property (moved_w && prev_q == bsl_pkg::BSL_ST_VALIDATE
    && state_out == bsl_pkg::BSL_ST_STANDBY |-> held_q >= (bsl_pkg::VALID_S - 1) * TICK_CYCLES
    && held_q <= (bsl_pkg::VALID_S + 1) * TICK_CYCLES) else $error("validation length wrong");
  AST_HEAT_START: assert property (moved_w && prev_q == bsl_pkg::BSL_ST_STANDBY &&
    state_out == bsl_pkg::BSL_ST_PURGE_HI |-> $past(field_in.call_heat, 3))
    else $error("purge without heat call");
  AST_PURGE_DRIVE: assert property (state_out == bsl_pkg::BSL_ST_PURGE_HI && !moved_w
    |-> drive_out.blower && drive_out.drive_hi) else $error("purge start drive missing");
  AST_STBY_SENSE: assert property (state_out == bsl_pkg::BSL_ST_STANDBY && sense_in.main
    ##1 sense_in.main [*3] |-> lock_w) else $error("energized main in standby");
  AST_RUN_FLAME: assert property (state_out == bsl_pkg::BSL_ST_RUN && !field_in.flame
    ##1 !field_in.flame [*3] |-> lock_w) else $error("flame loss in run");
endmodule
bind bsl_core bsl_core_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .field_in(field_in), .sense_in(sense_in),
  .supply_ok_in(supply_ok_in), .card_ok_in(card_ok_in), .int_fault_in(int_fault_in),
  .lockout_reset_in(lockout_reset_in), .drive_out(drive_out), .state_out(state_out));
`default_nettype wire

// ---- test/bsl_field_model.sv ----
// field model: switches, flame and terminal sensing around the supervisor
// assumes the bench drives its commands at the rising clock edge
`timescale 1ns/1ps
`default_nettype none
module bsl_field_model (
  // clock and reset
  input  wire logic                ref_clk_in,
  input  wire logic                arst_n_in,
  // supervisor outputs and bench commands
  input  wire bsl_pkg::bsl_drive_t drive_in,
  input  wire logic                call_heat_in,
  input  wire logic                flame_force_in,
  input  wire logic                flame_kill_in,
  input  wire logic                pii_open_in,
  input  wire logic                sense_force_in,
  // field pins and sensing
  output bsl_pkg::bsl_field_t      field_out,
  output bsl_pkg::bsl_sense_t      sense_out
);
  // any fuel valve open lights the burner
  wire logic fuel_w = drive_in.pilot | drive_in.ipilot | drive_in.main;
  // terminals follow the relays at once, or are forced on
  assign sense_out = '{ign: drive_in.ign | sense_force_in, pilot: drive_in.pilot | sense_force_in,
    ipilot: drive_in.ipilot | sense_force_in, main: drive_in.main | sense_force_in};
  // switches and flame settle one cycle after the command
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      field_out <= '{burner_sw: 1'b1, limits: 1'b1, lockout_in: 1'b1, lo_fire_sw: 1'b1,
        preign_ilk: 1'b1, default: 1'b0};
    end else begin
      field_out.call_heat  <= call_heat_in;
      field_out.preign_ilk <= !pii_open_in;
      field_out.airflow    <= drive_in.blower;
      field_out.hi_fire_sw <= drive_in.drive_hi;
      field_out.lo_fire_sw <= !drive_in.drive_hi;
      field_out.flame      <= flame_force_in | (fuel_w & !flame_kill_in);
    end
  end
endmodule
`default_nettype wire

// ---- test/bsl_core_test.sv ----
// self-checking bench for the burner sequence and lockout supervisor
// assumes the field model closes the loop from outputs to pins
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin error_cnt++; \
  $display("BAD %0t value mismatch", $time); end end
module bsl_core_test;
  localparam int unsigned TK = 10;
  // bench drives
  logic                ref_clk_in = 1'b0;
  logic                arst_n_in  = 1'b0;
  logic                supply_ok  = 1'b1;
  logic                card_ok    = 1'b1;
  logic                int_fault  = 1'b0;
  logic                lk_rst     = 1'b0;
  logic [7:0]          cmd        = 8'h00;
  logic [10:0]         purge_s    = 11'h2;
  logic [2:0]          jumpers    = 3'h0;
  // observed and bookkeeping
  bsl_pkg::bsl_field_t field_w;
  bsl_pkg::bsl_sense_t sense_w;
  bsl_pkg::bsl_drive_t drive_out;
  bsl_pkg::bsl_state_t state_out;
  bsl_pkg::bsl_state_t last_st = bsl_pkg::BSL_ST_VALIDATE;
  bsl_pkg::bsl_state_t exp_q[$];
  bsl_pkg::bsl_state_t seq [9];
  int                  error_cnt = 0;
  int                  tests_run = 0;
  int                  cyc = 0;
  integer              seed;
  // cmd bits: heat, flame force, flame kill, interlock open, sense force
  bsl_core #(.TICK_CYCLES(TK)) DUT (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in),
    .field_in(field_w), .sense_in(sense_w), .supply_ok_in(supply_ok), .card_ok_in(card_ok),
    .card_purge_s_in(purge_s), .int_fault_in(int_fault), .jumpers_in(jumpers),
    .lockout_reset_in(lk_rst), .drive_out(drive_out), .state_out(state_out));
  bsl_field_model u_fld (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .drive_in(drive_out),
    .call_heat_in(cmd[0]), .flame_force_in(cmd[1]), .flame_kill_in(cmd[2]),
    .pii_open_in(cmd[3]), .sense_force_in(cmd[4]), .field_out(field_w), .sense_out(sense_w));
  always #2.5 ref_clk_in = ~ref_clk_in;
  // watch state changes against the oldest expectation
  always @(negedge ref_clk_in) begin
    if (arst_n_in && state_out !== last_st) begin
      if (exp_q.size() == 0) `CHK(state_out, last_st)
      else `CHK(state_out, exp_q.pop_front())
      last_st = state_out;
    end
  end
  // hang guard
  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      test_done();
    end
  end
  task automatic test_done();
    if (error_cnt == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask
  task automatic wait_st(input bsl_pkg::bsl_state_t s, input int n);
    int k;
    k = 0;
    while (state_out !== s && k < n) begin
      @(negedge ref_clk_in);
      k++;
    end
    `CHK(state_out, s)
    @(posedge ref_clk_in);
  endtask
  task automatic do_reset();
    arst_n_in <= 1'b0;
    tick(5);
    arst_n_in <= 1'b1;
    exp_q.delete();
    last_st = bsl_pkg::BSL_ST_VALIDATE;
    exp_q.push_back(bsl_pkg::BSL_ST_STANDBY);
    wait_st(bsl_pkg::BSL_ST_STANDBY, 3 * TK);
  endtask
  task automatic lock_end(input int n);
    wait_st(bsl_pkg::BSL_ST_LOCKOUT, n);
    tick(4 * TK);
    `CHK(state_out, bsl_pkg::BSL_ST_LOCKOUT)
    `CHK(drive_out.alarm, 1'b1)
    `CHK({drive_out.ign, drive_out.pilot, drive_out.ipilot, drive_out.main}, 4'h0)
    {supply_ok, card_ok, int_fault, cmd} <= 11'h600;
    do_reset();
  endtask
  task automatic run_up();
    foreach (seq[i]) exp_q.push_back(seq[i]);
    cmd[0] <= 1'b1;
    wait_st(bsl_pkg::BSL_ST_RUN, 60 * TK);
  endtask
  task automatic expect_st(input bsl_pkg::bsl_state_t a, input bsl_pkg::bsl_state_t b);
    exp_q.push_back(a);
    exp_q.push_back(b);
  endtask
  // main sequence
  initial begin
    seed = 32'h796bbf38;
    seq = '{bsl_pkg::BSL_ST_PURGE_HI, bsl_pkg::BSL_ST_PURGE, bsl_pkg::BSL_ST_PURGE_LO,
      bsl_pkg::BSL_ST_PREIGN, bsl_pkg::BSL_ST_SAFETY1, bsl_pkg::BSL_ST_PILOT,
      bsl_pkg::BSL_ST_MAIN, bsl_pkg::BSL_ST_MAINSTAB, bsl_pkg::BSL_ST_RUN};
    for (int i = 0; i < 3; i++) begin
      purge_s <= 11'h2 + 11'($unsigned($random(seed)) % 9);
      jumpers <= {1'b0, 2'($random(seed))};
      do_reset();
      run_up();
      `CHK({drive_out.main, drive_out.ign, drive_out.drive_lo, drive_out.blower}, 4'h9)
      expect_st(bsl_pkg::BSL_ST_POST, bsl_pkg::BSL_ST_STANDBY);
      cmd[0] <= 1'b0;
      wait_st(bsl_pkg::BSL_ST_STANDBY, 20 * TK);
    end
    lk_rst <= 1'b1;
    tick(20);
    lk_rst <= 1'b0;
    `CHK(state_out, bsl_pkg::BSL_ST_STANDBY)
    run_up();
    exp_q.push_back(bsl_pkg::BSL_ST_LOCKOUT);
    cmd[2] <= 1'b1;
    lock_end(10);
    exp_q.push_back(bsl_pkg::BSL_ST_LOCKOUT);
    cmd[1] <= 1'b1;
    tick(36 * TK);
    `CHK(state_out, bsl_pkg::BSL_ST_STANDBY)
    lock_end(6 * TK);
    exp_q.push_back(bsl_pkg::BSL_ST_LOCKOUT);
    cmd[3] <= 1'b1;
    tick(20 * TK);
    cmd[3] <= 1'b0;
    tick(5 * TK);
    cmd[3] <= 1'b1;
    tick(8 * TK);
    `CHK(state_out, bsl_pkg::BSL_ST_STANDBY)
    lock_end(4 * TK);
    exp_q.push_back(bsl_pkg::BSL_ST_LOCKOUT);
    cmd[4] <= 1'b1;
    lock_end(8);
    exp_q.push_back(bsl_pkg::BSL_ST_LOCKOUT);
    card_ok <= 1'b0;
    lock_end(8);
    exp_q.push_back(bsl_pkg::BSL_ST_LOCKOUT);
    int_fault <= 1'b1;
    lock_end(8);
    exp_q.push_back(bsl_pkg::BSL_ST_HOLD);
    expect_st(bsl_pkg::BSL_ST_VALIDATE, bsl_pkg::BSL_ST_STANDBY);
    supply_ok <= 1'b0;
    tick(TK);
    supply_ok <= 1'b1;
    tick(2 * TK);
    `CHK({state_out, drive_out.hold}, {bsl_pkg::BSL_ST_HOLD, 1'b1})
    wait_st(bsl_pkg::BSL_ST_STANDBY, 10 * TK);
    expect_st(bsl_pkg::BSL_ST_HOLD, bsl_pkg::BSL_ST_LOCKOUT);
    supply_ok <= 1'b0;
    tick(236 * TK);
    `CHK(state_out, bsl_pkg::BSL_ST_HOLD)
    lock_end(8 * TK);
    test_done();
  end
endmodule
`default_nettype wire
